/* include/scsel_pkg.sv */
/*
  Shared constants, types and helpers of the speed command select and
  S-curve reference block. Assumes a 125 MHz drive clock.
*/
package scsel_pkg;

  localparam int SPD_W = 16;
  localparam int ACC_W = 18;
  localparam int XW = 40;
  localparam int NUM_SLOTS = 16;
  localparam int SEL_W = 4;
  localparam int NUM_CURVES = 4;
  localparam int NUM_PARAMS = 4;
  localparam int CSEL_W = 2;
  localparam int PAR_W = 2;
  localparam int CNT_W = 23;
  localparam int SCALE_FRAC = 8;

  localparam logic [PAR_W-1:0] PAR_ACCEL = 2'h0;
  localparam logic [PAR_W-1:0] PAR_DECEL = 2'h1;
  localparam logic [PAR_W-1:0] PAR_JERK = 2'h2;
  localparam logic [PAR_W-1:0] PAR_LJERK = 2'h3;

  localparam logic [1:0] ORG_NONE = 2'h0;
  localparam logic [1:0] ORG_INPUT = 2'h1;
  localparam logic [1:0] ORG_SERIAL = 2'h2;

  localparam logic [SEL_W-1:0] ZERO_SLOT = 4'h0;
  localparam logic [SPD_W-1:0] SPD_ZERO = 16'h0000;
  localparam logic [SPD_W-1:0] SPD_POS_MAX = 16'h7FFF;
  localparam logic [SPD_W-1:0] SPD_NEG_MAX = 16'h8000;

  // Clock rate and derived timing counts
  localparam int CLK_KHZ = 125000;
  localparam int FILTER_MS = 50;
  localparam int FILTER_CYC = FILTER_MS * CLK_KHZ;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = TICK_US * CLK_KHZ / 1000;

  typedef logic signed [SPD_W-1:0] scsel_spd_t;
  typedef logic signed [XW-1:0] scsel_wide_t;
  typedef enum logic [1:0] {PH_IDLE, PH_SPEEDUP, PH_SLOWDOWN} scsel_phase_t;

  function automatic scsel_spd_t scsel_sat(input scsel_wide_t v);
    if (v > $signed({24'h000000, SPD_POS_MAX})) begin
      return scsel_spd_t'(SPD_POS_MAX);
    end else if (v < -$signed({24'h000000, SPD_POS_MAX}) - 40'sh1) begin
      return scsel_spd_t'(SPD_NEG_MAX);
    end
    return v[SPD_W-1:0];
  endfunction : scsel_sat

  function automatic scsel_wide_t scsel_abs(input scsel_wide_t v);
    return (v < 0) ? -v : v;
  endfunction : scsel_abs

endpackage : scsel_pkg

/* include/scsel_ref_if.sv */
/*
  Link between the command selector and the S-curve limiter.
  Assumes both ends run on the same drive clock.
*/
`timescale 1ns/1ps
interface scsel_ref_if;
  import scsel_pkg::*;
  logic tick;
  logic release_ref;
  scsel_spd_t cmd;
  logic [SPD_W-1:0] accel_rate;
  logic [SPD_W-1:0] decel_rate;
  logic [SPD_W-1:0] jerk_rate;
  logic [SPD_W-1:0] level_jerk;
  scsel_spd_t speed_ref;
  scsel_phase_t phase;

  modport drv (
    output tick, release_ref, cmd, accel_rate, decel_rate, jerk_rate,
    output level_jerk,
    input speed_ref, phase
  );
  modport lim (
    input tick, release_ref, cmd, accel_rate, decel_rate, jerk_rate,
    input level_jerk,
    output speed_ref, phase
  );
endinterface : scsel_ref_if

/* core/scsel_scurve.sv */
/*
  S-curve limiter: shapes the speed command into the speed reference,
  one step per tick. Assumes the selector supplies tick and parameters.
*/
`timescale 1ns/1ps
module scsel_scurve
  import scsel_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_arst_n,
  scsel_ref_if.lim lif
);

  typedef struct packed {
    scsel_spd_t speed_ref;
    logic signed [ACC_W-1:0] acc;
    scsel_phase_t phase;
  } scsel_lim_t;

  scsel_lim_t s_q;
  scsel_lim_t s_d;
  scsel_wide_t err;
  scsel_wide_t acc;
  scsel_wide_t ades;
  scsel_wide_t anew;
  scsel_wide_t nref;
  scsel_wide_t rate;
  scsel_wide_t jlev;
  scsel_wide_t jsel;
  logic up;
  logic speedup;
  logic round_off;

  always_comb begin
    s_d = s_q;
    err = scsel_wide_t'(lif.cmd) - scsel_wide_t'(s_q.speed_ref);
    acc = scsel_wide_t'(s_q.acc);
    up = err > 0;
    speedup = (s_q.speed_ref == 0) || ((s_q.speed_ref > 0) == up);
    rate = speedup ? $signed({24'h000000, lif.accel_rate})
                   : $signed({24'h000000, lif.decel_rate});
    // Leaving decel rounds with the leveling jerk
    jlev = speedup ? $signed({24'h000000, lif.jerk_rate})
                   : $signed({24'h000000, lif.level_jerk});
    round_off = (jlev != 0) && (acc * acc >= 2 * jlev * scsel_abs(err));
    ades = round_off ? 40'sh0 : (up ? rate : -rate);
    jsel = (scsel_abs(ades) > scsel_abs(acc))
           ? $signed({24'h000000, lif.jerk_rate}) : jlev;
    if (jsel == 0) begin
      anew = ades;
    end else if (ades > acc) begin
      anew = (acc + jsel > ades) ? ades : acc + jsel;
    end else begin
      anew = (acc - jsel < ades) ? ades : acc - jsel;
    end
    nref = scsel_wide_t'(s_q.speed_ref) + anew;
    if (!lif.release_ref) begin
      s_d.speed_ref = '0;
      s_d.acc = '0;
      s_d.phase = PH_IDLE;
    end else if (lif.tick) begin
      if (err == 0) begin
        s_d.acc = '0;
        s_d.phase = PH_IDLE;
      end else if (rate == 0) begin
        s_d.speed_ref = lif.cmd;
        s_d.acc = '0;
        s_d.phase = PH_IDLE;
      end else if (up ? (nref >= err + scsel_wide_t'(s_q.speed_ref))
                      : (nref <= err + scsel_wide_t'(s_q.speed_ref))) begin
        s_d.speed_ref = lif.cmd;
        s_d.acc = '0;
        s_d.phase = speedup ? PH_SPEEDUP : PH_SLOWDOWN;
      end else begin
        s_d.speed_ref = scsel_sat(nref);
        s_d.acc = anew[ACC_W-1:0];
        s_d.phase = speedup ? PH_SPEEDUP : PH_SLOWDOWN;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '{speed_ref: '0, acc: '0, phase: PH_IDLE};
    end else begin
      s_q <= s_d;
    end
  end

  assign lif.speed_ref = s_q.speed_ref;
  assign lif.phase = s_q.phase;

endmodule : scsel_scurve

/* core/scsel_top.sv */
/*
  Speed command selection, direction, overspeed test and S-curve
  parameter selection front end of the elevator drive.
  Assumes all logic inputs are synchronous to i_clock and that software
  loads speed slots and S-curve sets through the write ports.
*/
// Overview of operation
// - Fifteen programmable slots, slot zero fixed zero
// - Four select bits binary pick slot index
// - Unassigned select bits read as zero
// - Assigned direction input true negates the command
// - New select code accepted after 50 ms
// - Overspeed test scales command, bypasses level limit
// - Overspeed request origin gates input and serial
// - Overspeed test arms on rising request only
// - Armed test applies on next run start
// - S-curve limiter output is the speed reference
// - Each curve set holds four rate parameters
// - Jerk for most transitions, leveling jerk otherwise
// - Four curve sets picked by two-bit code
// - Unassigned curve select inputs read as zero
// - Zero jerk disables jerk limiting
// - Zero accel or decel disables rate limit
// - Motor rpm from contract car and motor speed
`timescale 1ns/1ps
module scsel_top
  import scsel_pkg::*;
#(
  parameter int unsigned P_FILTER_CYCLES = FILTER_CYC,
  parameter int unsigned P_TICK_CYCLES = TICK_CYC
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_slot_wr,
  input wire logic [SEL_W-1:0] i_slot_addr,
  input wire logic [SPD_W-1:0] i_slot_data,
  input wire logic i_curve_wr,
  input wire logic [CSEL_W-1:0] i_curve_set_addr,
  input wire logic [PAR_W-1:0] i_curve_param_addr,
  input wire logic [SPD_W-1:0] i_curve_data,
  input wire logic [SEL_W-1:0] i_step_select,
  input wire logic [SEL_W-1:0] i_step_assigned,
  input wire logic i_direction_invert_input,
  input wire logic i_direction_assigned,
  input wire logic i_curve_select_low,
  input wire logic i_curve_select_high,
  input wire logic [CSEL_W-1:0] i_curve_assigned,
  input wire logic [1:0] i_overspeed_request_origin,
  input wire logic i_overspeed_request_input,
  input wire logic i_overspeed_request_serial,
  input wire logic i_overspeed_request_operator,
  input wire logic [SPD_W-1:0] i_overspeed_scale_factor,
  input wire logic [SPD_W-1:0] i_overspeed_level,
  input wire logic i_run,
  input wire logic i_ref_release,
  input wire logic [SPD_W-1:0] i_contract_car_speed,
  input wire logic [SPD_W-1:0] i_contract_motor_speed,
  output logic [SEL_W-1:0] o_step_index,
  output logic [CSEL_W-1:0] o_curve_index,
  output scsel_spd_t o_speed_command,
  output scsel_spd_t o_speed_ref,
  output scsel_spd_t o_motor_speed_ref,
  output scsel_phase_t o_phase,
  output logic o_overspeed_armed,
  output logic o_overspeed_active
);

  localparam logic [CNT_W-1:0] FILT_LAST = CNT_W'(P_FILTER_CYCLES - 1);
  localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(P_TICK_CYCLES - 1);
  localparam int NUM_CPAR = NUM_CURVES * NUM_PARAMS;

  typedef struct packed {
    logic [NUM_SLOTS-1:1][SPD_W-1:0] slots;
    logic [NUM_CPAR-1:0][SPD_W-1:0] curves;
    logic [SEL_W-1:0] cand;
    logic [SEL_W-1:0] step;
    logic [CNT_W-1:0] fcnt;
    logic [CNT_W-1:0] tcnt;
    logic tick;
    logic req_prev;
    logic run_prev;
    logic armed;
    logic active;
    logic [CSEL_W-1:0] curve;
    scsel_spd_t cmd;
    scsel_spd_t rpm;
  } scsel_state_t;

  scsel_state_t s_q;
  scsel_state_t s_d;
  scsel_ref_if lif ();

  logic [SEL_W-1:0] raw_code;
  logic req_now;
  logic req_edge;
  logic run_start;
  scsel_wide_t slot_val;
  scsel_wide_t signed_val;
  scsel_wide_t scaled;
  scsel_wide_t lim;
  scsel_wide_t prod;

  // Index of one parameter inside the flat curve store
  function automatic logic [CSEL_W+PAR_W-1:0] cpar_idx(
    input logic [CSEL_W-1:0] set,
    input logic [PAR_W-1:0] par
  );
    return {set, par};
  endfunction : cpar_idx

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;

    // Parameter stores; slot zero has no storage
    if (i_slot_wr && (i_slot_addr != ZERO_SLOT)) begin
      s_d.slots[i_slot_addr] = i_slot_data;
    end
    if (i_curve_wr) begin
      s_d.curves[cpar_idx(i_curve_set_addr, i_curve_param_addr)] =
        i_curve_data;
    end

    // Step select stability filter
    raw_code = i_step_select & i_step_assigned;
    if (raw_code != s_q.cand) begin
      s_d.cand = raw_code;
      s_d.fcnt = '0;
    end else if (s_q.fcnt == FILT_LAST) begin
      s_d.step = s_q.cand;
    end else begin
      s_d.fcnt = s_q.fcnt + 1'b1;
    end

    // Limiter update rate
    if (s_q.tcnt == TICK_LAST) begin
      s_d.tcnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.tcnt = s_q.tcnt + 1'b1;
    end

    // Overspeed request origin and edge
    req_now = ((i_overspeed_request_origin == ORG_INPUT) &&
               i_overspeed_request_input) ||
              ((i_overspeed_request_origin == ORG_SERIAL) &&
               i_overspeed_request_serial) ||
              i_overspeed_request_operator;
    req_edge = req_now && !s_q.req_prev;
    s_d.req_prev = req_now;
    run_start = i_run && !s_q.run_prev;
    s_d.run_prev = i_run;
    if (run_start) begin
      s_d.active = s_q.armed;
    end else if (!i_run) begin
      s_d.active = 1'b0;
    end
    // A new request in the start cycle waits for the next run
    s_d.armed = req_edge || (s_q.armed && !run_start);

    // Command path
    if (s_q.step == ZERO_SLOT) begin
      slot_val = '0;
    end else begin
      slot_val = scsel_wide_t'($signed(s_q.slots[s_q.step]));
    end
    if (i_direction_assigned && i_direction_invert_input) begin
      signed_val = -slot_val;
    end else begin
      signed_val = slot_val;
    end
    scaled = (signed_val * $signed({24'h000000, i_overspeed_scale_factor}))
             >>> SCALE_FRAC;
    lim = $signed({24'h000000, i_overspeed_level});
    if (s_q.active) begin
      s_d.cmd = scsel_sat(scaled);
    end else if (signed_val > lim) begin
      s_d.cmd = scsel_sat(lim);
    end else if (signed_val < -lim) begin
      s_d.cmd = scsel_sat(-lim);
    end else begin
      s_d.cmd = scsel_sat(signed_val);
    end

    // Curve set selection
    s_d.curve = {i_curve_select_high && i_curve_assigned[1],
                 i_curve_select_low && i_curve_assigned[0]};

    // Car speed units to motor rpm
    prod = scsel_wide_t'(lif.speed_ref) *
           $signed({24'h000000, i_contract_motor_speed});
    if (i_contract_car_speed == SPD_ZERO) begin
      s_d.rpm = '0;
    end else begin
      s_d.rpm = scsel_sat(prod / $signed({24'h000000,
                                          i_contract_car_speed}));
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Limiter feed from the selected curve set
  assign lif.tick = s_q.tick;
  assign lif.release_ref = i_ref_release;
  assign lif.cmd = s_q.cmd;
  assign lif.accel_rate = s_q.curves[cpar_idx(s_q.curve, PAR_ACCEL)];
  assign lif.decel_rate = s_q.curves[cpar_idx(s_q.curve, PAR_DECEL)];
  assign lif.jerk_rate = s_q.curves[cpar_idx(s_q.curve, PAR_JERK)];
  assign lif.level_jerk = s_q.curves[cpar_idx(s_q.curve, PAR_LJERK)];

  scsel_scurve i_scsel_scurve (
    .i_clock (i_clock),
    .i_arst_n (i_arst_n),
    .lif (lif.lim)
  );

  assign o_step_index = s_q.step;
  assign o_curve_index = s_q.curve;
  assign o_speed_command = s_q.cmd;
  assign o_speed_ref = lif.speed_ref;
  assign o_motor_speed_ref = s_q.rpm;
  assign o_phase = lif.phase;
  assign o_overspeed_armed = s_q.armed;
  assign o_overspeed_active = s_q.active;

endmodule : scsel_top

/* verif/scsel_top_asserts.sv */
/* Port checker of scsel_top: filter, curve select, overspeed, release.
   Assumes a bind to scsel_top with its filter parameter passed on. */
`timescale 1ns/1ps
module scsel_top_asserts
  import scsel_pkg::*;
#(
  parameter int unsigned P_FILTER_CYCLES = FILTER_CYC
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic [SEL_W-1:0] i_step_select,
  input wire logic [SEL_W-1:0] i_step_assigned,
  input wire logic i_curve_select_low,
  input wire logic i_curve_select_high,
  input wire logic [CSEL_W-1:0] i_curve_assigned,
  input wire logic [1:0] i_overspeed_request_origin,
  input wire logic i_overspeed_request_input,
  input wire logic i_overspeed_request_serial,
  input wire logic i_overspeed_request_operator,
  input wire logic i_run,
  input wire logic i_ref_release,
  input wire logic [SEL_W-1:0] o_step_index,
  input wire logic [CSEL_W-1:0] o_curve_index,
  input wire scsel_spd_t o_speed_command,
  input wire scsel_spd_t o_speed_ref,
  input wire logic o_overspeed_armed,
  input wire logic o_overspeed_active
);
  logic [SEL_W-1:0] raw;
  logic [CSEL_W-1:0] csel;
  logic req;
  logic [SEL_W-1:0] raw_q;
  int unsigned cnt_q;
  assign raw = i_step_select & i_step_assigned;
  assign csel = {i_curve_select_high & i_curve_assigned[1],
                 i_curve_select_low & i_curve_assigned[0]};
  assign req = i_overspeed_request_operator
    | (i_overspeed_request_origin == ORG_INPUT && i_overspeed_request_input)
    | (i_overspeed_request_origin == ORG_SERIAL && i_overspeed_request_serial);
  // Cycles the masked code has stayed unchanged
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      raw_q <= '0;
      cnt_q <= 0;
    end else begin
      raw_q <= raw;
      if (raw != raw_q) begin
        cnt_q <= 0;
      end else if (cnt_q < P_FILTER_CYCLES) begin
        cnt_q <= cnt_q + 1;
      end
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  AST_STEP_CHANGE: assert property ($changed(o_step_index) |->
    $past(cnt_q) == P_FILTER_CYCLES - 1 && o_step_index == raw_q)
    else $error("step index changed before filter elapsed");
  AST_STEP_ACCEPT: assert property (cnt_q >= P_FILTER_CYCLES |->
    o_step_index == raw_q) else $error("stable step code not accepted");
  AST_CURVE: assert property ($past(i_arst_n) |->
    o_curve_index == $past(csel)) else $error("curve index wrong");
  AST_ZERO_SLOT: assert property (o_step_index == ZERO_SLOT ##1
    o_step_index == ZERO_SLOT |-> o_speed_command == SPD_ZERO)
    else $error("slot zero not zero speed");
  AST_ARM: assert property ($rose(o_overspeed_armed) |->
    ($past(req) && !$past(req, 2)) || ($past(req, 2) && !$past(req, 3)))
    else $error("armed without request edge");
  AST_ACTIVE_RISE: assert property ($rose(o_overspeed_active) |->
    $past(o_overspeed_armed) && $past(i_run))
    else $error("test active without arming and run");
  AST_ARM_CLEAR: assert property ($fell(o_overspeed_armed) |->
    o_overspeed_active) else $error("armed dropped without run");
  AST_ACTIVE_END: assert property (!i_run ##1 !i_run |->
    !o_overspeed_active) else $error("test active outside run");
  AST_RELEASE: assert property (!i_ref_release ##1 !i_ref_release |->
    o_speed_ref == SPD_ZERO) else $error("reference not held at zero");
endmodule : scsel_top_asserts

/* verif/scsel_ctrl_model.sv */
/* Car controller model driving the discrete logic inputs.
   Assumes the bench calls apply; changes land 1 ns after a rising edge. */
`timescale 1ns/1ps
module scsel_ctrl_model (
  input wire logic i_clock,
  output logic [3:0] o_step_select,
  output logic o_direction_invert_input,
  output logic o_curve_select_low,
  output logic o_curve_select_high,
  output logic o_overspeed_request_input,
  output logic o_run
);
  initial begin
    o_step_select = 4'h0;
    {o_direction_invert_input, o_curve_select_low} = 2'h0;
    {o_curve_select_high, o_overspeed_request_input, o_run} = 3'h0;
  end
  // Slots are all positive, so direction input carries the sign
  task automatic apply(input logic [3:0] s, input logic d, lo, hi, rq, rn);
    @(posedge i_clock);
    #1;
    o_step_select = s;
    o_direction_invert_input = d;
    o_curve_select_low = lo;
    o_curve_select_high = hi;
    o_overspeed_request_input = rq;
    o_run = rn;
  endtask : apply
endmodule : scsel_ctrl_model

/* verif/scsel_top_bench.sv */
/* Self-checking bench of scsel_top with a car controller model.
   Assumes short filter and tick counts; all rates left at zero. */
`timescale 1ns/1ps
module scsel_top_bench;
  import scsel_pkg::*;
  localparam int unsigned FILT = 20;
  logic i_clock, i_arst_n, slot_wr, curve_wr, dir_asg, req_ser, req_op;
  logic ref_rel, step, dir, clo, chi, req_in, run, armed, active;
  logic [3:0] slot_addr, step_asg, idx;
  logic [3:0] step_sel;
  logic [1:0] cset, cpar, c_asg, origin, cidx;
  logic [15:0] slot_data, cdata, scale, level, car, motor;
  scsel_spd_t cmd, sref, mref;
  scsel_phase_t phase;
  logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h8, 4'hF, 4'h5};
  int fail_count = 0;
  int tests_run = 0;
  scsel_ctrl_model i_scsel_ctrl_model (.i_clock(i_clock),
    .o_step_select(step_sel), .o_direction_invert_input(dir),
    .o_curve_select_low(clo), .o_curve_select_high(chi),
    .o_overspeed_request_input(req_in), .o_run(run));
  scsel_top #(.P_FILTER_CYCLES(FILT), .P_TICK_CYCLES(4)) i_scsel_top (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .i_slot_wr(slot_wr),
    .i_slot_addr(slot_addr), .i_slot_data(slot_data),
    .i_curve_wr(curve_wr), .i_curve_set_addr(cset),
    .i_curve_param_addr(cpar), .i_curve_data(cdata),
    .i_step_select(step_sel), .i_step_assigned(step_asg),
    .i_direction_invert_input(dir), .i_direction_assigned(dir_asg),
    .i_curve_select_low(clo), .i_curve_select_high(chi),
    .i_curve_assigned(c_asg), .i_overspeed_request_origin(origin),
    .i_overspeed_request_input(req_in), .i_overspeed_request_serial(req_ser),
    .i_overspeed_request_operator(req_op), .i_overspeed_scale_factor(scale),
    .i_overspeed_level(level), .i_run(run), .i_ref_release(ref_rel),
    .i_contract_car_speed(car), .i_contract_motor_speed(motor),
    .o_step_index(idx), .o_curve_index(cidx), .o_speed_command(cmd),
    .o_speed_ref(sref), .o_motor_speed_ref(mref), .o_phase(phase),
    .o_overspeed_armed(armed), .o_overspeed_active(active));
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : tick
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  initial begin
    #160000;
    fail_count++;
    end_sim();
  end
  initial begin
    {slot_wr, slot_addr, slot_data, curve_wr, cset, cpar, cdata} = '0;
    {step_asg, dir_asg, c_asg, origin} = {4'hF, 1'b1, 2'h3, ORG_INPUT};
    {req_ser, req_op, ref_rel, scale, level} = {3'h1, 16'h0200, 16'h7FFF};
    {car, motor, i_arst_n} = {16'h0100, 16'h0200, 1'b0};
    tick(16);
    i_arst_n = 1'b1;
    slot_wr = 1'b1;
    for (int k = 0; k < 16; k++) begin
      slot_addr = 4'(k);
      slot_data = (k == 0) ? 16'h1234 : {4'h0, 4'(k), 8'h00};
      tick(1);
    end
    slot_wr = 1'b0;
    // All rates and jerks zero: no rate limit, limiter jumps to command on the next tick
    curve_wr = 1'b1;
    for (int k = 0; k < 16; k++) begin
      {cset, cpar} = 4'(k);
      tick(1);
    end
    curve_wr = 1'b0;
    foreach (codes[k]) begin
      i_scsel_ctrl_model.apply(codes[k], 0, 0, 0, 0, 0);
      tick(FILT + 3);
      chk(16'(idx), 16'(codes[k]));
      chk(cmd, {4'h0, codes[k], 8'h00});
    end
    // Brief all-open code must not be taken
    i_scsel_ctrl_model.apply(4'h0, 0, 0, 0, 0, 0);
    tick(10);
    chk(16'(idx), 16'h0005);
    i_scsel_ctrl_model.apply(4'h5, 0, 0, 0, 0, 0);
    tick(FILT + 3);
    chk(16'(idx), 16'h0005);
    step_asg = 4'h7;
    i_scsel_ctrl_model.apply(4'hF, 0, 0, 0, 0, 0);
    tick(FILT + 3);
    chk(16'(idx), 16'h0007);
    step_asg = 4'hF;
    i_scsel_ctrl_model.apply(4'h5, 1, 0, 0, 0, 0);
    tick(FILT + 3);
    chk(cmd, 16'hFB00);
    dir_asg = 1'b0;
    tick(3);
    chk(cmd, 16'h0500);
    dir_asg = 1'b1;
    i_scsel_ctrl_model.apply(4'h5, 0, 0, 0, 0, 0);
    for (int k = 0; k < 200 && sref !== 16'h0500; k++) tick(1);
    chk(sref, 16'h0500);
    tick(1);
    chk(mref, 16'h0A00);
    chk(16'(phase), 16'(PH_IDLE));
    ref_rel = 1'b0;
    tick(3);
    chk(sref, 16'h0000);
    ref_rel = 1'b1;
    for (int k = 0; k < 4; k++) begin
      i_scsel_ctrl_model.apply(4'h5, 0, k[0], k[1], 0, 0);
      tick(3);
      chk(16'(cidx), 16'(k));
    end
    c_asg = 2'h1;
    tick(3);
    chk(16'(cidx), 16'h0001);
    c_asg = 2'h3;
    level = 16'h0400;
    tick(3);
    chk(cmd, 16'h0400);
    i_scsel_ctrl_model.apply(4'h5, 0, 0, 0, 1, 0);
    tick(3);
    chk(16'(armed), 16'h0001);
    i_scsel_ctrl_model.apply(4'h5, 0, 0, 0, 1, 1);
    tick(3);
    chk(16'(active), 16'h0001);
    chk(cmd, 16'h0A00);
    i_scsel_ctrl_model.apply(4'h5, 0, 0, 0, 1, 0);
    tick(3);
    chk(16'(active), 16'h0000);
    chk(16'(armed), 16'h0000);
    origin = ORG_NONE;
    i_scsel_ctrl_model.apply(4'h5, 0, 0, 0, 0, 0);
    i_scsel_ctrl_model.apply(4'h5, 0, 0, 0, 1, 0);
    tick(3);
    chk(16'(armed), 16'h0000);
    req_op = 1'b1;
    tick(3);
    chk(16'(armed), 16'h0001);
    end_sim();
  end
endmodule : scsel_top_bench
bind scsel_top scsel_top_asserts #(.P_FILTER_CYCLES(P_FILTER_CYCLES))
  i_scsel_top_asserts (.i_clock(i_clock), .i_arst_n(i_arst_n),
  .i_step_select(i_step_select), .i_step_assigned(i_step_assigned),
  .i_curve_select_low(i_curve_select_low),
  .i_curve_select_high(i_curve_select_high),
  .i_curve_assigned(i_curve_assigned),
  .i_overspeed_request_origin(i_overspeed_request_origin),
  .i_overspeed_request_input(i_overspeed_request_input),
  .i_overspeed_request_serial(i_overspeed_request_serial),
  .i_overspeed_request_operator(i_overspeed_request_operator),
  .i_run(i_run), .i_ref_release(i_ref_release),
  .o_step_index(o_step_index), .o_curve_index(o_curve_index),
  .o_speed_command(o_speed_command), .o_speed_ref(o_speed_ref),
  .o_overspeed_armed(o_overspeed_armed),
  .o_overspeed_active(o_overspeed_active));
